/* core/sdrc_mem_end.sv */
// Purpose: Memory end: command decode, bank rows, bursts, byte masks, array
// Assumes: All link inputs are synchronous to clk; one read latency of two
// Notes:   Array contents are not cleared by reset
// Contract
// - Masked read lane floats two clocks later
// - Masked write lane discarded same edge
// - Inputs captured on rising clock edge
// - Edge ignored while clock gate low
// - Gate low enters down, suspend or self-refresh
// - Clock gate sensed directly, not via register
// - Deselected: ignore commands, keep running operations
// - Three strobes together encode the command
// - Activate latches eleven-bit row per bank
// - Column in low eight bits, bit ten auto-precharges
// - Precharge bit ten closes all, else one
// - Bank select names the target bank
// - Load mode takes address lines as mode
// - Mask bit n governs data byte n
// - Array is four banks of 2048 rows, 256 columns, 32 bits
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_cfg.svh"
module sdrc_mem_end (
  sdrc_if.mem                              lnk,
  input  wire logic                        sys_rst,
  output logic [`SDRC_ROW_W-1:0]           mode_setting,
  output sdrc_pkg::sdrc_pwr_e              power_state,
  output logic [`SDRC_NBANK-1:0]           banks_open
);
  import sdrc_pkg::*;

  sdrc_mem_s                     s_reg;
  sdrc_mem_s                     s_next;
  sdrc_mem_s                     s_rst;

  logic [`SDRC_DATA_W-1:0]       mem_array [0:`SDRC_WORDS-1];
  logic [`SDRC_DATA_W-1:0]       mem_rd_reg;
  logic [`SDRC_DATA_W-1:0]       old_word;
  logic [`SDRC_DATA_W-1:0]       wr_word;

  logic [2:0]                    cmd;
  logic                          edge_ok;
  logic                          cmd_go;
  logic                          is_pre;
  logic                          acc_new;
  logic                          acc_cont;
  logic [`SDRC_BANK_W-1:0]       acc_bank;
  logic [`SDRC_COL_W-1:0]        acc_col;
  logic                          acc_wr;
  logic                          rd_go;
  logic                          wr_go;
  logic                          last_beat;
  logic [`SDRC_BEAT_W-1:0]       blen_m1;
  logic [`SDRC_IDX_W-1:0]        mem_idx;

  // Clock gate is used as it stands at this edge, with no register
  assign edge_ok  = lnk.clk_gate && !sys_rst;
  assign cmd      = {lnk.row_strobe_n, lnk.col_strobe_n, lnk.write_strobe_n};
  assign cmd_go   = edge_ok && !lnk.cmd_sel_n;
  assign is_pre   = cmd_go && (cmd == `SDRC_CMD_PRE);
  assign blen_m1  = sdrc_blen_m1(s_reg.mode[`SDRC_MODE_BL_LSB +: `SDRC_MODE_BL_W]);

  // Read or write to an open bank starts a burst
  assign acc_new  = cmd_go && ((cmd == `SDRC_CMD_RD) || (cmd == `SDRC_CMD_WR)) &&
                    s_reg.open[lnk.bank_select];
  // Burst carries on over deselected edges, stops on precharge
  assign acc_cont = edge_ok && !acc_new && !is_pre &&
                    (s_reg.brst_left != 3'h0);
  assign acc_bank = acc_new ? lnk.bank_select : s_reg.brst_bank;
  assign acc_col  = acc_new ? lnk.address_lines[`SDRC_COL_W-1:0] : s_reg.brst_col;
  assign acc_wr   = acc_new ? (cmd == `SDRC_CMD_WR) : s_reg.brst_wr;
  assign rd_go    = (acc_new || acc_cont) && !acc_wr;
  assign wr_go    = (acc_new || acc_cont) && acc_wr;
  assign last_beat = (acc_new && (blen_m1 == 3'h0) && lnk.address_lines[`SDRC_AP_BIT]) ||
                     (acc_cont && (s_reg.brst_left == 3'h1) && s_reg.brst_ap);

  // Word index is bank, open row, column
  assign mem_idx  = {acc_bank, s_reg.row[acc_bank], acc_col};
  assign old_word = mem_array[mem_idx];

  // Byte lanes merge old and new data under the write mask
  for (genvar lane = 0; lane < `SDRC_MASK_W; lane++) begin : g_wmask
    assign wr_word[lane*8 +: 8] = lnk.byte_mask[lane] ? old_word[lane*8 +: 8] :
                                  lnk.data_lines[lane*8 +: 8];
  end

  // Array write and read, both only on a valid edge
  always_ff @(posedge lnk.clk) begin
    if (wr_go) begin
      mem_array[mem_idx] <= wr_word;
    end
    if (rd_go) begin
      mem_rd_reg <= old_word;
    end
  end

  always_comb begin
    s_rst           = '0;
    s_rst.pwr       = SDRC_PWR_ACTIVE;
    s_rst.mode      = `SDRC_MODE_RST;
    s_rst.oe_n      = {`SDRC_MASK_W{1'b1}};
    s_rst.dstage    = `SDRC_WORD_RST;
    s_rst.dout      = `SDRC_WORD_RST;
  end

  always_comb begin
    s_next = s_reg;
    if (!lnk.clk_gate) begin
      // Edge is invalid, only the low-activity state moves
      case (s_reg.pwr)
        SDRC_PWR_ACTIVE: begin
          if (!lnk.cmd_sel_n && (cmd == `SDRC_CMD_REF)) begin
            s_next.pwr = SDRC_PWR_SELFREF;
          end else if (s_reg.rd_p1 || s_reg.rd_p2 || (s_reg.brst_left != 3'h0)) begin
            s_next.pwr = SDRC_PWR_SUSPEND;
          end else begin
            s_next.pwr = SDRC_PWR_DOWN;
          end
        end
        SDRC_PWR_DOWN: begin
          s_next.pwr = SDRC_PWR_DOWN;
        end
        SDRC_PWR_SUSPEND: begin
          s_next.pwr = SDRC_PWR_SUSPEND;
        end
        SDRC_PWR_SELFREF: begin
          s_next.pwr = SDRC_PWR_SELFREF;
        end
        default: begin
          s_next.pwr = SDRC_PWR_ACTIVE;
        end
      endcase
    end else begin
      s_next.pwr = SDRC_PWR_ACTIVE;

      // Read pipeline, mask sampled with the beat and applied two edges on
      s_next.rd_p1  = rd_go;
      s_next.msk1   = lnk.byte_mask;
      s_next.rd_p2  = s_reg.rd_p1;
      s_next.msk2   = s_reg.msk1;
      s_next.dstage = mem_rd_reg;
      s_next.dout   = s_reg.dstage;
      s_next.oe_n   = {`SDRC_MASK_W{~s_reg.rd_p2}} | s_reg.msk2;

      // Clear first so an activate on the same edge wins
      if (last_beat) begin
        s_next.open[acc_bank] = 1'b0;
      end

      if (cmd_go) begin
        case (cmd)
          `SDRC_CMD_ACT: begin
            s_next.open[lnk.bank_select] = 1'b1;
            s_next.row[lnk.bank_select]  = lnk.address_lines;
          end
          `SDRC_CMD_PRE: begin
            if (lnk.address_lines[`SDRC_AP_BIT]) begin
              s_next.open = {`SDRC_NBANK{1'b0}};
            end else begin
              s_next.open[lnk.bank_select] = 1'b0;
            end
            s_next.brst_left = 3'h0;
          end
          `SDRC_CMD_REF: begin
            s_next.mode = s_reg.mode;
          end
          `SDRC_CMD_LMR: begin
            s_next.mode = lnk.address_lines;
          end
          default: begin
            s_next.mode = s_reg.mode;
          end
        endcase
      end

      // Burst address and auto-precharge bookkeeping
      if (acc_new) begin
        s_next.brst_left = blen_m1;
        s_next.brst_col  = acc_col + 8'h01;
        s_next.brst_bank = acc_bank;
        s_next.brst_wr   = acc_wr;
        s_next.brst_ap   = lnk.address_lines[`SDRC_AP_BIT];
      end else if (acc_cont) begin
        s_next.brst_left = s_reg.brst_left - 3'h1;
        s_next.brst_col  = s_reg.brst_col + 8'h01;
      end
    end
  end

  always_ff @(posedge lnk.clk) begin
    if (sys_rst) begin
      s_reg <= s_rst;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.dq_mem      = s_reg.dout;
  assign lnk.dq_mem_oe_n = s_reg.oe_n;
  assign mode_setting    = s_reg.mode;
  assign power_state     = s_reg.pwr;
  assign banks_open      = s_reg.open;

endmodule : sdrc_mem_end
`default_nettype wire

/* core/sdrc_cfg.svh */
// Purpose: Constants shared by both ends of the memory command link
// Assumes: Single clock, one command per rising edge
// Notes:   Command codes are {row_strobe_n, col_strobe_n, write_strobe_n}
`ifndef SDRC_CFG_SVH
`define SDRC_CFG_SVH

`define SDRC_ROW_W        11
`define SDRC_COL_W        8
`define SDRC_BANK_W       2
`define SDRC_NBANK        4
`define SDRC_DATA_W       32
`define SDRC_MASK_W       4
`define SDRC_ROWS         2048
`define SDRC_COLS         256
`define SDRC_WORDS        (`SDRC_NBANK * `SDRC_ROWS * `SDRC_COLS)
`define SDRC_IDX_W        21
`define SDRC_AP_BIT       10
`define SDRC_MODE_BL_LSB  0
`define SDRC_MODE_BL_W    3
`define SDRC_BEAT_W       3
`define SDRC_RD_PIPE      4

`define SDRC_CMD_NOP      3'h7
`define SDRC_CMD_ACT      3'h3
`define SDRC_CMD_RD       3'h5
`define SDRC_CMD_WR       3'h4
`define SDRC_CMD_PRE      3'h2
`define SDRC_CMD_REF      3'h1
`define SDRC_CMD_LMR      3'h0

`define SDRC_MODE_RST     11'h000
`define SDRC_ROW_RST      11'h000
`define SDRC_WORD_RST     32'h00000000

`endif

/* core/sdrc_pkg.sv */
// Purpose: Types shared by the memory end and the controller end
// Assumes: Constants come from sdrc_cfg.svh
// Notes:   Burst length code 0..3 gives 1, 2, 4, 8 beats
`include "sdrc_cfg.svh"
package sdrc_pkg;

  typedef enum logic [3:0] {
    SDRC_PWR_ACTIVE  = 4'h1,
    SDRC_PWR_DOWN    = 4'h2,
    SDRC_PWR_SUSPEND = 4'h4,
    SDRC_PWR_SELFREF = 4'h8
  } sdrc_pwr_e;

  typedef enum logic [2:0] {
    SDRC_OP_NOP   = 3'h0,
    SDRC_OP_ACT   = 3'h1,
    SDRC_OP_READ  = 3'h2,
    SDRC_OP_WRITE = 3'h3,
    SDRC_OP_PRE   = 3'h4,
    SDRC_OP_REF   = 3'h5,
    SDRC_OP_LMR   = 3'h6,
    SDRC_OP_DATA  = 3'h7
  } sdrc_op_e;

  typedef struct packed {
    sdrc_pwr_e                                  pwr;
    logic [`SDRC_ROW_W-1:0]                     mode;
    logic [`SDRC_NBANK-1:0]                     open;
    logic [`SDRC_NBANK-1:0][`SDRC_ROW_W-1:0]    row;
    logic [`SDRC_BEAT_W-1:0]                    brst_left;
    logic [`SDRC_COL_W-1:0]                     brst_col;
    logic [`SDRC_BANK_W-1:0]                    brst_bank;
    logic                                       brst_wr;
    logic                                       brst_ap;
    logic                                       rd_p1;
    logic                                       rd_p2;
    logic [`SDRC_MASK_W-1:0]                    msk1;
    logic [`SDRC_MASK_W-1:0]                    msk2;
    logic [`SDRC_DATA_W-1:0]                    dstage;
    logic [`SDRC_DATA_W-1:0]                    dout;
    logic [`SDRC_MASK_W-1:0]                    oe_n;
  } sdrc_mem_s;

  typedef struct packed {
    logic                                       cke;
    logic                                       cs_n;
    logic                                       ras_n;
    logic                                       cas_n;
    logic                                       we_n;
    logic [`SDRC_BANK_W-1:0]                    bank;
    logic [`SDRC_ROW_W-1:0]                     addr;
    logic [`SDRC_MASK_W-1:0]                    mask;
    logic [`SDRC_DATA_W-1:0]                    dq;
    logic                                       dq_oe_n;
    logic [`SDRC_BEAT_W-1:0]                    blen_m1;
    logic [`SDRC_BEAT_W-1:0]                    rd_left;
    logic [`SDRC_RD_PIPE-1:0]                   rd_pipe;
    logic                                       rd_valid;
    logic [`SDRC_DATA_W-1:0]                    rd_data;
  } sdrc_ctl_s;

  function automatic logic [`SDRC_BEAT_W-1:0] sdrc_blen_m1(
    input logic [`SDRC_MODE_BL_W-1:0] code
  );
    case (code)
      3'h1:    sdrc_blen_m1 = 3'h1;
      3'h2:    sdrc_blen_m1 = 3'h3;
      3'h3:    sdrc_blen_m1 = 3'h7;
      default: sdrc_blen_m1 = 3'h0;
    endcase
  endfunction : sdrc_blen_m1

endpackage : sdrc_pkg

/* core/sdrc_if.sv */
// Purpose: Pin bundle between memory controller and memory
// Assumes: Controller and memory share clk
// Notes:   Data wire level is resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_cfg.svh"
interface sdrc_if (
  input wire logic clk
);
  logic                      clk_gate;
  logic                      cmd_sel_n;
  logic                      row_strobe_n;
  logic                      col_strobe_n;
  logic                      write_strobe_n;
  logic [`SDRC_BANK_W-1:0]   bank_select;
  logic [`SDRC_ROW_W-1:0]    address_lines;
  logic [`SDRC_MASK_W-1:0]   byte_mask;
  logic [`SDRC_DATA_W-1:0]   dq_ctl;
  logic                      dq_ctl_oe_n;
  logic [`SDRC_DATA_W-1:0]   dq_mem;
  logic [`SDRC_MASK_W-1:0]   dq_mem_oe_n;
  logic [`SDRC_DATA_W-1:0]   data_lines;

  // Per-lane wire level, memory wins, undriven reads zero
  for (genvar lane = 0; lane < `SDRC_MASK_W; lane++) begin : g_lane
    assign data_lines[lane*8 +: 8] = !dq_mem_oe_n[lane] ? dq_mem[lane*8 +: 8] :
                                     (!dq_ctl_oe_n ? dq_ctl[lane*8 +: 8] : 8'h00);
  end

  modport mem (
    input  clk, clk_gate, cmd_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
    input  bank_select, address_lines, byte_mask, data_lines,
    output dq_mem, dq_mem_oe_n
  );

  modport ctl (
    input  clk, data_lines,
    output clk_gate, cmd_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
    output bank_select, address_lines, byte_mask, dq_ctl, dq_ctl_oe_n
  );
endinterface : sdrc_if
`default_nettype wire

/* core/sdrc_ctl_end.sv */
// Purpose: Controller end: turns user requests into link commands
// Assumes: One request per cycle; user keeps refresh and command spacing
// Notes:   Read data returns four clocks after the issuing edge
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_cfg.svh"
module sdrc_ctl_end (
  sdrc_if.ctl                              lnk,
  input  wire logic                        sys_rst,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire sdrc_pkg::sdrc_op_e          req_op,
  input  wire logic [`SDRC_BANK_W-1:0]     req_bank,
  input  wire logic [`SDRC_ROW_W-1:0]      req_addr,
  input  wire logic [`SDRC_MASK_W-1:0]     req_mask,
  input  wire logic [`SDRC_DATA_W-1:0]     req_wdata,
  input  wire logic                        sleep_req,
  output logic                             rd_valid,
  output logic [`SDRC_DATA_W-1:0]          rd_data
);
  import sdrc_pkg::*;

  sdrc_ctl_s                     s_reg;
  sdrc_ctl_s                     s_next;
  logic [2:0]                    op_code;
  logic                          take;
  logic                          beat;

  assign req_ready = !sys_rst;
  assign take      = req_valid && req_ready;
  assign beat      = s_reg.rd_left != 3'h0;

  // Request kind to strobe pattern
  always_comb begin
    case (req_op)
      SDRC_OP_ACT:   op_code = `SDRC_CMD_ACT;
      SDRC_OP_READ:  op_code = `SDRC_CMD_RD;
      SDRC_OP_WRITE: op_code = `SDRC_CMD_WR;
      SDRC_OP_PRE:   op_code = `SDRC_CMD_PRE;
      SDRC_OP_REF:   op_code = `SDRC_CMD_REF;
      SDRC_OP_LMR:   op_code = `SDRC_CMD_LMR;
      default:       op_code = `SDRC_CMD_NOP;
    endcase
  end

  always_comb begin
    s_next         = s_reg;
    s_next.cke     = !sleep_req;
    s_next.cs_n    = 1'b1;
    {s_next.ras_n, s_next.cas_n, s_next.we_n} = `SDRC_CMD_NOP;
    s_next.dq_oe_n = 1'b1;
    if (beat) begin
      s_next.rd_left = s_reg.rd_left - 3'h1;
    end
    if (take) begin
      if ((req_op != SDRC_OP_NOP) && (req_op != SDRC_OP_DATA)) begin
        s_next.cs_n = 1'b0;
        {s_next.ras_n, s_next.cas_n, s_next.we_n} = op_code;
        s_next.bank = req_bank;
        s_next.addr = req_addr;
      end
      s_next.mask = req_mask;
      if ((req_op == SDRC_OP_WRITE) || (req_op == SDRC_OP_DATA)) begin
        s_next.dq      = req_wdata;
        s_next.dq_oe_n = 1'b0;
      end
      if (req_op == SDRC_OP_READ) begin
        s_next.rd_left = s_reg.blen_m1;
      end
      if (req_op == SDRC_OP_LMR) begin
        s_next.blen_m1 = sdrc_blen_m1(req_addr[`SDRC_MODE_BL_LSB +: `SDRC_MODE_BL_W]);
      end
    end
    s_next.rd_pipe  = {s_reg.rd_pipe[`SDRC_RD_PIPE-2:0],
                       (take && (req_op == SDRC_OP_READ)) || beat};
    s_next.rd_valid = s_reg.rd_pipe[`SDRC_RD_PIPE-1];
    if (s_reg.rd_pipe[`SDRC_RD_PIPE-1]) begin
      s_next.rd_data = lnk.data_lines;
    end
  end

  // All link outputs come from this register, stable across the edge
  always_ff @(posedge lnk.clk) begin
    if (sys_rst) begin
      s_reg         <= '0;
      s_reg.cke     <= 1'b1;
      s_reg.cs_n    <= 1'b1;
      s_reg.ras_n   <= 1'b1;
      s_reg.cas_n   <= 1'b1;
      s_reg.we_n    <= 1'b1;
      s_reg.dq_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lnk.clk_gate       = s_reg.cke;
  assign lnk.cmd_sel_n      = s_reg.cs_n;
  assign lnk.row_strobe_n   = s_reg.ras_n;
  assign lnk.col_strobe_n   = s_reg.cas_n;
  assign lnk.write_strobe_n = s_reg.we_n;
  assign lnk.bank_select    = s_reg.bank;
  assign lnk.address_lines  = s_reg.addr;
  assign lnk.byte_mask      = s_reg.mask;
  assign lnk.dq_ctl         = s_reg.dq;
  assign lnk.dq_ctl_oe_n    = s_reg.dq_oe_n;
  assign rd_valid           = s_reg.rd_valid;
  assign rd_data            = s_reg.rd_data;

endmodule : sdrc_ctl_end
`default_nettype wire

/* verif/sdrc_link_monitor.sv */
// Purpose: Checker on the link between controller end and memory end
// Assumes: One clock, synchronous active-high reset
// Notes:   Bank and burst shadows err on the side of not firing
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_cfg.svh"
module sdrc_link_monitor (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    clk_gate,
  input wire logic                    cmd_sel_n,
  input wire logic                    row_strobe_n,
  input wire logic                    col_strobe_n,
  input wire logic                    write_strobe_n,
  input wire logic [`SDRC_BANK_W-1:0] bank_select,
  input wire logic [`SDRC_ROW_W-1:0]  address_lines,
  input wire logic [`SDRC_MASK_W-1:0] byte_mask,
  input wire logic                    dq_ctl_oe_n,
  input wire logic [`SDRC_MASK_W-1:0] dq_mem_oe_n
);
  logic [`SDRC_NBANK-1:0] open_reg;
  logic [2:0]             blc_reg;
  logic [2:0]             code;
  logic                   hit;
  logic                   rd_hit;
  logic                   bl1;

  assign code   = {row_strobe_n, col_strobe_n, write_strobe_n};
  assign hit    = clk_gate && !cmd_sel_n;
  assign rd_hit = hit && (code == `SDRC_CMD_RD);
  assign bl1    = (blc_reg == 3'h0) || blc_reg[2];

  // Shadow of open banks and burst code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      open_reg <= 4'h0;
      blc_reg  <= 3'h0;
    end else if (hit) begin
      case (code)
        `SDRC_CMD_ACT: open_reg[bank_select] <= 1'h1;
        `SDRC_CMD_PRE: open_reg <= address_lines[10] ? 4'h0 : open_reg & ~(4'h1 << bank_select);
        `SDRC_CMD_RD, `SDRC_CMD_WR: begin
          if (address_lines[`SDRC_AP_BIT]) begin
            open_reg[bank_select] <= 1'h0;
          end
        end
        `SDRC_CMD_LMR: blc_reg <= address_lines[2:0];
        default: ;
      endcase
    end
  end

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_gate2;
    clk_gate [*2];
  endsequence
  sequence s_rd_open;
    rd_hit && open_reg[bank_select];
  endsequence
  sequence s_rd2;
    s_rd_open ##0 (blc_reg == 3'h1 && byte_mask == 4'h0)
    ##1 (clk_gate && cmd_sel_n && $stable(byte_mask)) [*4];
  endsequence

  chk_mask_float: assert property (
    !(&dq_mem_oe_n) && $past(clk_gate, 1) && $past(clk_gate, 2) && $past(clk_gate, 3)
    |-> (~dq_mem_oe_n & $past(byte_mask, 3)) == 4'h0)
    else $error("masked read lane driven");
  chk_rd_lanes: assert property (
    s_rd_open ##1 s_gate2 |=> dq_mem_oe_n == $past(byte_mask, 3))
    else $error("read lanes do not follow byte mask");
  chk_rd_closed: assert property (
    rd_hit && !open_reg[bank_select] && bl1 ##1 s_gate2 |=> &dq_mem_oe_n)
    else $error("closed bank answered a read");
  chk_rd_origin: assert property (
    !(&dq_mem_oe_n) && bl1 && $past(clk_gate, 1) && $past(clk_gate, 2) && $past(clk_gate, 3)
    |-> $past(rd_hit, 3))
    else $error("data driven without read");
  chk_gate_hold: assert property (
    !clk_gate |=> $stable(dq_mem_oe_n))
    else $error("memory output moved on gated edge");
  chk_wr_drive: assert property (
    hit && code == `SDRC_CMD_WR |-> !dq_ctl_oe_n)
    else $error("write without data driven");
  chk_cmd_code: assert property (
    !cmd_sel_n |-> code != 3'h6)
    else $error("undefined command code");
  chk_burst_two: assert property (
    s_rd2 |-> $past(dq_mem_oe_n) == 4'h0 && dq_mem_oe_n == 4'h0 ##1 &dq_mem_oe_n)
    else $error("two-beat burst wrong");
endmodule : sdrc_link_monitor
`default_nettype wire

/* verif/sdr_sdram_command_interface_tb_top.sv */
// Purpose: Self-checking bench joining controller end and memory end
// Assumes: 100 MHz clock, reset held 20 cycles, inputs change on falling edge
// Notes:   Masked or undriven read lanes come back as zero
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_cfg.svh"
module sdr_sdram_command_interface_tb_top;
  import sdrc_pkg::*;
  logic                    clk;
  logic                    sys_rst;
  logic                    req_valid;
  logic                    req_ready;
  sdrc_op_e                req_op;
  logic [`SDRC_BANK_W-1:0] req_bank;
  logic [`SDRC_ROW_W-1:0]  req_addr;
  logic [`SDRC_MASK_W-1:0] req_mask;
  logic [`SDRC_DATA_W-1:0] req_wdata;
  logic                    sleep_req;
  logic                    rd_valid;
  logic [`SDRC_DATA_W-1:0] rd_data;
  logic [`SDRC_ROW_W-1:0]  mode_setting;
  sdrc_pwr_e               power_state;
  logic [`SDRC_NBANK-1:0]  banks_open;
  logic [3:0]              pins;
  logic [`SDRC_DATA_W-1:0] got [0:7];
  int                      err_total;
  int                      comparisons;

  sdrc_if i_sdrc_if (.clk(clk));
  sdrc_mem_end i_sdrc_mem_end (.lnk(i_sdrc_if), .sys_rst(sys_rst), .mode_setting(mode_setting),
    .power_state(power_state), .banks_open(banks_open));
  sdrc_ctl_end i_sdrc_ctl_end (.lnk(i_sdrc_if), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_bank(req_bank), .req_addr(req_addr),
    .req_mask(req_mask), .req_wdata(req_wdata), .sleep_req(sleep_req),
    .rd_valid(rd_valid), .rd_data(rd_data));
  sdrc_link_monitor i_sdrc_link_monitor (.clk(clk), .sys_rst(sys_rst),
    .clk_gate(i_sdrc_if.clk_gate), .cmd_sel_n(i_sdrc_if.cmd_sel_n),
    .row_strobe_n(i_sdrc_if.row_strobe_n), .col_strobe_n(i_sdrc_if.col_strobe_n),
    .write_strobe_n(i_sdrc_if.write_strobe_n), .bank_select(i_sdrc_if.bank_select),
    .address_lines(i_sdrc_if.address_lines), .byte_mask(i_sdrc_if.byte_mask),
    .dq_ctl_oe_n(i_sdrc_if.dq_ctl_oe_n), .dq_mem_oe_n(i_sdrc_if.dq_mem_oe_n));

  assign pins = {i_sdrc_if.cmd_sel_n, i_sdrc_if.row_strobe_n, i_sdrc_if.col_strobe_n,
                 i_sdrc_if.write_strobe_n};

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
    end
  endtask : chk

  function automatic logic [2:0] cmd_code(input sdrc_op_e op);
    case (op)
      SDRC_OP_ACT:   cmd_code = 3'h3;
      SDRC_OP_READ:  cmd_code = 3'h5;
      SDRC_OP_WRITE: cmd_code = 3'h4;
      SDRC_OP_PRE:   cmd_code = 3'h2;
      SDRC_OP_REF:   cmd_code = 3'h1;
      default:       cmd_code = 3'h0;
    endcase
  endfunction : cmd_code

  // One request, then the link pins it produced
  task automatic issue(input sdrc_op_e op, input logic [1:0] bank, input logic [10:0] addr,
                       input logic [3:0] mask, input logic [31:0] data);
    @(negedge clk);
    req_valid = 1'h1;
    req_op    = op;
    req_bank  = bank;
    req_addr  = addr;
    req_mask  = mask;
    req_wdata = data;
    @(posedge clk);
    #1;
    if (op == SDRC_OP_NOP || op == SDRC_OP_DATA) begin
      chk(i_sdrc_if.cmd_sel_n, 1'h1, "no command");
    end else begin
      chk(pins, {1'h0, cmd_code(op)}, "command code");
      chk({i_sdrc_if.bank_select, i_sdrc_if.address_lines}, {bank, addr}, "bank addr");
    end
    if (op inside {SDRC_OP_READ, SDRC_OP_WRITE, SDRC_OP_DATA}) begin
      chk(i_sdrc_if.byte_mask, mask, "mask pins");
    end
    if (op inside {SDRC_OP_WRITE, SDRC_OP_DATA}) begin
      chk(i_sdrc_if.data_lines, data, "write data on wire");
    end
  endtask : issue

  task automatic idle(input int n);
    @(negedge clk);
    req_valid = 1'h0;
    req_op    = SDRC_OP_NOP;
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic rd(input logic [1:0] bank, input logic [10:0] addr, input logic [3:0] mask,
                    input int beats);
    int k;
    k = 0;
    issue(SDRC_OP_READ, bank, addr, mask, 32'h0);
    idle(0);
    for (int w = 0; w < 12 && k < beats; w++) begin
      @(negedge clk);
      if (rd_valid === 1'h1) begin
        got[k] = rd_data;
        k++;
      end
    end
    chk(k, beats, "beat count");
  endtask : rd

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    err_total   = 0;
    comparisons = 0;
    sys_rst     = 1'h1;
    req_valid   = 1'h0;
    req_op      = SDRC_OP_NOP;
    req_bank    = 2'h0;
    req_addr    = 11'h000;
    req_mask    = 4'h0;
    req_wdata   = 32'h0;
    sleep_req   = 1'h0;
    repeat (20) @(negedge clk);
    chk(req_ready, 1'h0, "ready in reset");
    sys_rst = 1'h0;
    chk(power_state, SDRC_PWR_ACTIVE, "power after reset");
    chk(mode_setting, 11'h000, "mode after reset");
    chk(banks_open, 4'h0, "banks after reset");
    issue(SDRC_OP_LMR, 2'h0, 11'h230, 4'h0, 32'h0);
    idle(2);
    chk(mode_setting, 11'h230, "mode load");
    chk(req_ready, 1'h1, "ready after reset");
    for (int b = 0; b < 4; b++) begin
      issue(SDRC_OP_ACT, 2'(b), 11'h7A5 ^ 11'(b), 4'h0, 32'h0);
    end
    idle(2);
    chk(banks_open, 4'hF, "all banks open");
    // Back-to-back writes, second one partly masked
    issue(SDRC_OP_WRITE, 2'h1, 11'h05A, 4'h0, 32'h11223344);
    issue(SDRC_OP_WRITE, 2'h1, 11'h05A, 4'h5, 32'hAABBCCDD);
    issue(SDRC_OP_WRITE, 2'h2, 11'h05A, 4'h0, 32'h55667788);
    idle(2);
    rd(2'h1, 11'h05A, 4'h0, 1);
    chk(got[0], 32'hAA22CC44, "masked write");
    rd(2'h1, 11'h05A, 4'h8, 1);
    chk(got[0], 32'h0022CC44, "masked read lane");
    rd(2'h2, 11'h45A, 4'h0, 1);
    chk(got[0], 32'h55667788, "bank separation");
    idle(2);
    chk(banks_open, 4'hB, "auto precharge");
    rd(2'h2, 11'h05A, 4'h0, 1);
    chk(got[0], 32'h0, "read of closed bank");
    issue(SDRC_OP_PRE, 2'h0, 11'h000, 4'h0, 32'h0);
    idle(2);
    chk(banks_open, 4'hA, "single precharge");
    issue(SDRC_OP_PRE, 2'h0, 11'h400, 4'h0, 32'h0);
    idle(2);
    chk(banks_open, 4'h0, "precharge all");
    issue(SDRC_OP_REF, 2'h0, 11'h000, 4'h0, 32'h0);
    issue(SDRC_OP_NOP, 2'h0, 11'h000, 4'h0, 32'h0);
    // Two-beat bursts
    issue(SDRC_OP_LMR, 2'h0, 11'h001, 4'h0, 32'h0);
    issue(SDRC_OP_ACT, 2'h3, 11'h123, 4'h0, 32'h0);
    idle(2);
    issue(SDRC_OP_WRITE, 2'h3, 11'h0FE, 4'h0, 32'hCAFE0001);
    issue(SDRC_OP_DATA, 2'h3, 11'h000, 4'h0, 32'h600D0002);
    idle(2);
    rd(2'h3, 11'h0FE, 4'h0, 2);
    chk(got[0], 32'hCAFE0001, "burst beat 0");
    chk(got[1], 32'h600D0002, "burst beat 1");
    // Gated clock: power-down ignores commands
    sleep_req = 1'h1;
    idle(4);
    chk(power_state, SDRC_PWR_DOWN, "power down");
    issue(SDRC_OP_ACT, 2'h0, 11'h011, 4'h0, 32'h0);
    idle(2);
    sleep_req = 1'h0;
    idle(4);
    chk(power_state, SDRC_PWR_ACTIVE, "wake");
    chk(banks_open, 4'h8, "gated command ignored");
    // Write burst cut by the clock gate, resumed on wake
    issue(SDRC_OP_WRITE, 2'h3, 11'h010, 4'h0, 32'h5A5A0003);
    @(negedge clk);
    req_valid = 1'h0;
    req_op    = SDRC_OP_NOP;
    sleep_req = 1'h1;
    idle(3);
    chk(power_state, SDRC_PWR_SUSPEND, "clock suspend");
    sleep_req = 1'h0;
    idle(4);
    chk(power_state, SDRC_PWR_ACTIVE, "leave suspend");
    rd(2'h3, 11'h010, 4'h0, 2);
    chk(got[0], 32'h5A5A0003, "suspended burst beat 0");
    chk(got[1], 32'h0, "suspended burst beat 1");
    @(negedge clk);
    req_valid = 1'h1;
    req_op    = SDRC_OP_REF;
    sleep_req = 1'h1;
    idle(4);
    chk(power_state, SDRC_PWR_SELFREF, "self refresh");
    sleep_req = 1'h0;
    idle(4);
    chk(power_state, SDRC_PWR_ACTIVE, "leave self refresh");
    tally_and_finish();
  end

  // Run takes under 150 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule : sdr_sdram_command_interface_tb_top
`default_nettype wire
